// ===== dv/dss_driver_status_props.sv
// Purpose : port assertions for the driver status block
// Assumes : single clock aclk, synchronous active low reset
// Notes   : watches only top level ports, attached by bind below
`timescale 1ns/1ps
`default_nettype none
module dss_driver_status_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        short_ground_a_det,
  input wire logic        short_ground_b_det,
  input wire logic        temp_prewarn_det,
  input wire logic        temp_limit_det,
  input wire logic        driver_enable_n_pin,
  input wire logic        driver_stage_en,
  input wire logic [3:0]  chopper_off_time
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // properties
  property p_rsv_zero;
    s_axi_rvalid |-> s_axi_rdata[23:21] == 3'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
  property p_short_off;
    (short_ground_a_det || short_ground_b_det) && driver_stage_en |-> ##2 !driver_stage_en;
  endproperty
  a_short_off: assert property (p_short_off) else $error("stage on after short");
  property p_hot_off;
    temp_limit_det |-> ##2 !driver_stage_en;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("stage on when hot");
  property p_hot_hold;
    temp_limit_det ##1 temp_prewarn_det [*3] |-> !driver_stage_en;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("stage on in prewarn");
  property p_en_offt;
    driver_stage_en |-> $past(chopper_off_time) != 4'h0;
  endproperty
  a_en_offt: assert property (p_en_offt) else $error("stage on with off time zero");
  property p_pin_off;
    driver_enable_n_pin [*4] |-> !driver_stage_en;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("stage on with pin high");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule

bind dss_driver_status dss_driver_status_props u_props (
  .aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .short_ground_a_det, .short_ground_b_det, .temp_prewarn_det,
  .temp_limit_det, .driver_enable_n_pin, .driver_stage_en, .chopper_off_time);
`default_nettype wire

// ===== dv/testbench.sv
// Purpose : self-checking bench for the driver status block
// Assumes : short standstill count, registers over axi4-lite
// Notes   : reads are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.vh"
module testbench;
  localparam int          ST   = 32;
  localparam logic [11:0] A_ST = {`DSS_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CT = {`DSS_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_IS = {`DSS_IDX_INT_STAT, 2'b00};
  localparam logic [11:0] A_IM = {`DSS_IDX_INT_MASK, 2'b00};
  localparam logic [1:0]  OK   = `DSS_RESP_OKAY;
  localparam logic [1:0]  SE   = `DSS_RESP_SLVERR;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, driver_stage_en, irq;
  logic        step_pin = 0, driver_enable_n_pin = 1, open_load_a_det = 0, open_load_b_det = 0;
  logic        short_ground_a_det = 0, short_ground_b_det = 0, temp_prewarn_det = 0;
  logic        temp_limit_det = 0, speed_ctrl_mode = 0, speed_ctrl_stall = 0;
  logic        fullstep_active = 0, e_sa = 0, e_sb = 0, e_th = 0, e_ss = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hdc363257;
  logic [3:0]  s_axi_wstrb = 4'hf, chopper_off_time;
  logic [1:0]  s_axi_bresp, s_axi_rresp, qb[$];
  logic [9:0]  load_measure_value = 10'h3ff;
  logic [4:0]  current_scale = 0;
  logic [33:0] qr[$];
  int          fail_count = 0, num_checks = 0;

  always #5 aclk = ~aclk;

  dss_driver_status #(.ADDR_W(12), .STST_CYCLES(21'(ST))) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_pin, .driver_enable_n_pin,
    .open_load_a_det, .open_load_b_det, .short_ground_a_det, .short_ground_b_det,
    .temp_prewarn_det, .temp_limit_det, .load_measure_value, .speed_ctrl_mode,
    .speed_ctrl_stall, .current_scale, .fullstep_active, .driver_stage_en,
    .chopper_off_time, .irq);

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected status word from held inputs and tracked latches
  function automatic logic [33:0] st();
    return {OK, e_ss, open_load_b_det, open_load_a_det, e_sb, e_sa, temp_prewarn_det, e_th,
            load_measure_value == 10'h0 || (speed_ctrl_mode && speed_ctrl_stall), 3'h0,
            current_scale, fullstep_active, 15'h0};
  endfunction
  task automatic ck(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one bus access; ready of the answer channel comes after a random stall
  task automatic xf(input bit w, input logic [11:0] a, input logic [33:0] e);
    int n = 0;
    @(posedge aclk);
    seed = lfsr(seed);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= e[31:0];
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    if (w) qb.push_back(e[33:32]);
    else qr.push_back(e);
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == seed[1:0]) {s_axi_bready, s_axi_rready} <= {w, !w};
      n++;
    end
    while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) && n < 99);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  task automatic conclude();
    ck("pending", 34'(qr.size() + qb.size()), 34'h0);
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) ck("rd", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
    if (s_axi_bvalid && s_axi_bready) ck("wr", 34'(s_axi_bresp), 34'(qb.pop_front()));
  end

  initial
  begin
    cyc(5000);
    fail_count++;
    conclude();
  end

  // ==========================================================
  // scenarios
  initial
  begin
    cyc(20);
    aresetn <= 1'b1;
    cyc(ST + 8);
    e_ss = 1;
    xf(0, A_CT, {OK, 32'h0});
    xf(0, A_IM, {OK, 32'h0});
    xf(0, 12'h004, {SE, 32'h0});
    xf(0, A_ST + 12'h1, {SE, 32'h0});
    xf(0, A_IS, {OK, 32'h1});
    xf(1, A_ST, {OK, 32'hffffffff});
    xf(1, A_IS, {OK, 32'hffffffff});
    xf(0, A_IS, {OK, 32'h0});
    xf(0, A_ST, st());
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      {current_scale, fullstep_active, temp_prewarn_det, speed_ctrl_mode} <= seed[7:0];
      {speed_ctrl_stall, open_load_a_det, open_load_b_det} <= seed[10:8];
      load_measure_value <= (i == 3) ? 10'h0 : seed[20:11];
      cyc(3);
      xf(0, A_ST, st());
      ck("irq", 34'(irq), 34'h0);
    end
    {open_load_a_det, open_load_b_det, temp_prewarn_det} <= 3'h0;
    load_measure_value <= 10'h3ff;
    driver_enable_n_pin <= 1'b0;
    xf(1, A_CT, {OK, 32'h5});
    {open_load_a_det, open_load_b_det} <= 2'h3;
    cyc(4);
    ck("offt", 34'(chopper_off_time), 34'h5);
    ck("en", 34'(driver_stage_en), 34'h1);
    s_axi_wstrb <= 4'he;
    xf(1, A_CT, {OK, 32'h0});
    s_axi_wstrb <= 4'hf;
    ck("offt", 34'(chopper_off_time), 34'h5);
    short_ground_a_det <= 1'b1;
    cyc(1);
    short_ground_a_det <= 1'b0;
    e_sa = 1;
    cyc(3);
    ck("en", 34'(driver_stage_en), 34'h0);
    xf(0, A_ST, st());
    xf(1, A_CT, {OK, 32'h0});
    e_sa = 0;
    xf(0, A_ST, st());
    xf(1, A_CT, {OK, 32'h5});
    cyc(2);
    short_ground_b_det <= 1'b1;
    cyc(1);
    short_ground_b_det <= 1'b0;
    e_sb = 1;
    xf(0, A_ST, st());
    driver_enable_n_pin <= 1'b1;
    e_sb = 0;
    cyc(5);
    xf(0, A_ST, st());
    driver_enable_n_pin <= 1'b0;
    {temp_limit_det, temp_prewarn_det} <= 2'h3;
    cyc(1);
    temp_limit_det <= 1'b0;
    e_th = 1;
    cyc(6);
    ck("en", 34'(driver_stage_en), 34'h0);
    xf(0, A_ST, st());
    temp_prewarn_det <= 1'b0;
    e_th = 0;
    cyc(4);
    ck("en", 34'(driver_stage_en), 34'h1);
    // step pulse, mode changed while the count runs
    step_pin <= 1'b1;
    cyc(2);
    step_pin <= 1'b0;
    speed_ctrl_mode <= !speed_ctrl_mode;
    e_ss = 0;
    cyc(4);
    xf(0, A_ST, st());
    e_ss = 1;
    cyc(ST);
    xf(0, A_ST, st());
    xf(0, A_IS, {OK, 32'h1f});
    xf(1, A_IM, {OK, 32'h1});
    xf(0, A_IM, {OK, 32'h1});
    step_pin <= 1'b1;
    cyc(2);
    step_pin <= 1'b0;
    cyc(4);
    ck("irq", 34'(irq), 34'h0);
    cyc(ST + 4);
    ck("irq", 34'(irq), 34'h1);
    xf(0, A_IS, {OK, 32'h1});
    cyc(2);
    ck("irq", 34'(irq), 34'h0);
    conclude();
  end
endmodule
`default_nettype wire

// ===== rtl/dss_defines.vh
// Purpose : constants for the driver status flag block
// Assumes : included by bare name from rtl/
// Notes   : indices are word indices, byte address is index * 4
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH

// ==========================================================
// register word indices
// ==========================================================
`define DSS_IDX_STATUS    10'h06f
`define DSS_IDX_CTRL      10'h06c
`define DSS_IDX_INT_STAT  10'h07e
`define DSS_IDX_INT_MASK  10'h07f

// ==========================================================
// status word fields
// ==========================================================
`define DSS_BIT_STANDSTILL   31
`define DSS_BIT_OPEN_B       30
`define DSS_BIT_OPEN_A       29
`define DSS_BIT_SHORT_B      28
`define DSS_BIT_SHORT_A      27
`define DSS_BIT_PREWARN      26
`define DSS_BIT_THERMAL      25
`define DSS_BIT_STALL        24
`define DSS_CS_MSB           20
`define DSS_CS_LSB           16
`define DSS_BIT_FULLSTEP     15

// ==========================================================
// interrupt event bits, same layout in status and mask
// ==========================================================
`define DSS_EV_STANDSTILL    0
`define DSS_EV_OPEN_LOAD     1
`define DSS_EV_SHORT         2
`define DSS_EV_THERMAL       3
`define DSS_EV_STALL         4
`define DSS_EV_W             5

// ==========================================================
// reset values, widths and timing
// ==========================================================
`define DSS_STST_CYCLES      21'h100000
`define DSS_OFFT_W           4
`define DSS_OFFT_RST         4'h0
`define DSS_MASK_RST         5'h00
`define DSS_RESP_OKAY        2'h0
`define DSS_RESP_SLVERR      2'h2
`define DSS_WORD_ZERO        32'h00000000

`endif

// ===== rtl/dss_driver_status.v
// Purpose : driver status word, driver stage gating and interrupt, on AXI4-Lite
// Assumes : single clock aclk; step and enable pins are asynchronous
// Notes   : detector inputs come from logic on aclk and are not synchronised
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.vh"

module dss_driver_status #(
  parameter                 ADDR_W      = 12,
  parameter [20:0]          STST_CYCLES = `DSS_STST_CYCLES
) (
  input  wire               aclk,
  input  wire               aresetn,
  // axi4-lite slave
  input  wire [ADDR_W-1:0]  s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [ADDR_W-1:0]  s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // pins
  input  wire               step_pin,
  input  wire               driver_enable_n_pin,
  // detectors and driver state, on aclk
  input  wire               open_load_a_det,
  input  wire               open_load_b_det,
  input  wire               short_ground_a_det,
  input  wire               short_ground_b_det,
  input  wire               temp_prewarn_det,
  input  wire               temp_limit_det,
  input  wire [9:0]         load_measure_value,
  input  wire               speed_ctrl_mode,
  input  wire               speed_ctrl_stall,
  input  wire [4:0]         current_scale,
  input  wire               fullstep_active,
  // outputs
  output reg                driver_stage_en,
  output reg  [`DSS_OFFT_W-1:0] chopper_off_time,
  output reg                irq
);

  // ==========================================================
  // helpers
  // ==========================================================
  function hit;
    input [ADDR_W-1:0] addr;
    input [9:0]        idx;
    begin
      hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  reg step_s1_ff;
  reg step_s2_ff;
  reg step_s3_ff;
  reg enn_s1_ff;
  reg enn_s2_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_s1_ff <= 1'b0;
      step_s2_ff <= 1'b0;
      step_s3_ff <= 1'b0;
      enn_s1_ff  <= 1'b1;
      enn_s2_ff  <= 1'b1;
    end
    else
    begin
      step_s1_ff <= step_pin;
      step_s2_ff <= step_s1_ff;
      step_s3_ff <= step_s2_ff;
      enn_s1_ff  <= driver_enable_n_pin;
      enn_s2_ff  <= enn_s1_ff;
    end
  end

  wire step_edge = step_s2_ff & ~step_s3_ff;

  // ==========================================================
  // flags
  // ==========================================================
  reg  [20:0] idle_cnt_ff;
  reg         standstill_ff;
  reg         open_a_ff;
  reg         open_b_ff;
  reg         short_a_ff;
  reg         short_b_ff;
  reg         prewarn_ff;
  reg         thermal_ff;
  reg         stall_ff;
  reg  [4:0]  cs_ff;
  reg         fullstep_ff;

  // disabling the driver is the only way out of a short latch
  wire drv_off = (chopper_off_time == `DSS_OFFT_RST) | enn_s2_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_cnt_ff   <= 21'h000000;
      standstill_ff <= 1'b0;
      open_a_ff     <= 1'b0;
      open_b_ff     <= 1'b0;
      short_a_ff    <= 1'b0;
      short_b_ff    <= 1'b0;
      prewarn_ff    <= 1'b0;
      thermal_ff    <= 1'b0;
      stall_ff      <= 1'b0;
      cs_ff         <= 5'h00;
      fullstep_ff   <= 1'b0;
    end
    else
    begin
      if (step_edge)
      begin
        idle_cnt_ff   <= 21'h000000;
        standstill_ff <= 1'b0;
      end
      else if (idle_cnt_ff != STST_CYCLES)
      begin
        idle_cnt_ff   <= idle_cnt_ff + 21'h000001;
        standstill_ff <= (idle_cnt_ff + 21'h000001) == STST_CYCLES;
      end
      else
        standstill_ff <= 1'b1;
      open_a_ff <= open_load_a_det;
      open_b_ff <= open_load_b_det;
      // clear wins while the driver is off, the stage is dead anyway
      short_a_ff <= ~drv_off & (short_a_ff | short_ground_a_det);
      short_b_ff <= ~drv_off & (short_b_ff | short_ground_b_det);
      prewarn_ff <= temp_prewarn_det;
      if (temp_limit_det)
        thermal_ff <= 1'b1;
      else if (!temp_prewarn_det)
        thermal_ff <= 1'b0;
      stall_ff <= (load_measure_value == 10'h000) |
                  (speed_ctrl_mode & speed_ctrl_stall);
      cs_ff       <= current_scale;
      fullstep_ff <= fullstep_active;
    end
  end

  // reserved bits tie to zero
  wire [31:0] status_word = {standstill_ff, open_b_ff, open_a_ff,
                             short_b_ff, short_a_ff, prewarn_ff,
                             thermal_ff, stall_ff, 3'h0, cs_ff,
                             fullstep_ff, 15'h0000};

  // ==========================================================
  // driver stage gating
  // ==========================================================
  always @(posedge aclk)
  begin
    if (!aresetn)
      driver_stage_en <= 1'b0;
    else
      // open load deliberately absent here
      driver_stage_en <= ~drv_off & ~short_a_ff & ~short_b_ff
                         & ~thermal_ff;
  end

  // ==========================================================
  // interrupt events
  // ==========================================================
  reg  [`DSS_EV_W-1:0] ev_prev_ff;
  reg  [`DSS_EV_W-1:0] int_stat_ff;
  reg  [`DSS_EV_W-1:0] int_mask_ff;
  wire [`DSS_EV_W-1:0] ev_level;
  wire [`DSS_EV_W-1:0] ev_rise;
  wire                 stat_rd_clr;
  wire                 mask_wr;
  wire [`DSS_EV_W-1:0] mask_wdata;

  assign ev_level[`DSS_EV_STANDSTILL] = standstill_ff;
  assign ev_level[`DSS_EV_OPEN_LOAD]  = open_a_ff | open_b_ff;
  assign ev_level[`DSS_EV_SHORT]      = short_a_ff | short_b_ff;
  assign ev_level[`DSS_EV_THERMAL]    = thermal_ff | prewarn_ff;
  assign ev_level[`DSS_EV_STALL]      = stall_ff;
  assign ev_rise = ev_level & ~ev_prev_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_prev_ff  <= {`DSS_EV_W{1'b0}};
      int_stat_ff <= {`DSS_EV_W{1'b0}};
      int_mask_ff <= `DSS_MASK_RST;
      irq         <= 1'b0;
    end
    else
    begin
      ev_prev_ff <= ev_level;
      // a new event in the clearing cycle survives the read
      int_stat_ff <= (stat_rd_clr ? {`DSS_EV_W{1'b0}} : int_stat_ff) | ev_rise;
      if (mask_wr)
        int_mask_ff <= mask_wdata;
      irq <= |(((stat_rd_clr ? {`DSS_EV_W{1'b0}} : int_stat_ff) | ev_rise)
              & (mask_wr ? mask_wdata : int_mask_ff));
    end
  end

  // ==========================================================
  // axi4-lite write channel
  // ==========================================================
  reg              aw_held_ff;
  reg              w_held_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg [31:0]       w_data_ff;
  reg [3:0]        w_strb_ff;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire wr_ctrl = do_wr & hit(aw_addr_ff, `DSS_IDX_CTRL);
  wire wr_mask = do_wr & hit(aw_addr_ff, `DSS_IDX_INT_MASK);
  wire wr_ro   = do_wr & (hit(aw_addr_ff, `DSS_IDX_STATUS) |
                          hit(aw_addr_ff, `DSS_IDX_INT_STAT));

  assign mask_wr = wr_mask & w_strb_ff[0];
  // held copy, the master may move wdata on once the beat is taken
  assign mask_wdata = w_data_ff[`DSS_EV_W-1:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff       <= 1'b0;
      w_held_ff        <= 1'b0;
      aw_addr_ff       <= {ADDR_W{1'b0}};
      w_data_ff        <= `DSS_WORD_ZERO;
      w_strb_ff        <= 4'h0;
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `DSS_RESP_OKAY;
      chopper_off_time <= `DSS_OFFT_RST;
    end
    else
    begin
      if (do_wr)
        aw_held_ff <= 1'b0;
      else if (aw_take)
        aw_held_ff <= 1'b1;
      if (do_wr)
        w_held_ff <= 1'b0;
      else if (w_take)
        w_held_ff <= 1'b1;
      if (aw_take)
        aw_addr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      s_axi_awready <= do_wr | ~(aw_held_ff | aw_take);
      s_axi_wready  <= do_wr | ~(w_held_ff | w_take);
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        // read-only words swallow writes quietly, holes answer slverr
        s_axi_bresp  <= (wr_ctrl | wr_mask | wr_ro) ? `DSS_RESP_OKAY
                                                    : `DSS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl & w_strb_ff[0])
        chopper_off_time <= w_data_ff[`DSS_OFFT_W-1:0];
    end
  end

  // ==========================================================
  // axi4-lite read channel
  // ==========================================================
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_stat = hit(s_axi_araddr, `DSS_IDX_STATUS);
  wire rd_ctrl = hit(s_axi_araddr, `DSS_IDX_CTRL);
  wire rd_ist  = hit(s_axi_araddr, `DSS_IDX_INT_STAT);
  wire rd_msk  = hit(s_axi_araddr, `DSS_IDX_INT_MASK);
  wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // only the interrupt status clears on read, the status word never
  assign stat_rd_clr = ar_take & rd_ist;

  reg [31:0] nxt_rdata;

  always @*
  begin
    nxt_rdata = `DSS_WORD_ZERO;
    if (rd_stat)
      nxt_rdata = status_word;
    else if (rd_ctrl)
      nxt_rdata[`DSS_OFFT_W-1:0] = chopper_off_time;
    else if (rd_ist)
      nxt_rdata[`DSS_EV_W-1:0] = int_stat_ff;
    else if (rd_msk)
      nxt_rdata[`DSS_EV_W-1:0] = int_mask_ff;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `DSS_WORD_ZERO;
      s_axi_rresp   <= `DSS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid  <= nxt_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= (rd_stat | rd_ctrl | rd_ist | rd_msk) ? `DSS_RESP_OKAY
                                                             : `DSS_RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire
